//--- rtl/bgrb_gauge_calc.sv
// Capacity sixteenths from count, reference and scale
`timescale 1ns/100ps
module bgrb_gauge_calc (
	input  wire logic [15:0]         count_in,   // Available charge count
	input  wire logic [7:0]          full_ref,   // Full reference, high byte units
	input  wire bgrb_pkg::bgrb_scale_e scale,    // Cold correction regime
	output logic      [3:0]          sixteenths  // Capacity in sixteenths
);
	logic [19:0] scaled;
	logic [19:0] ratio;
	always_comb begin
		case (scale)
			bgrb_pkg::SCALE_3Q:   scaled = 20'({count_in, 2'b00} - {2'b00, count_in}) >> 2;
			bgrb_pkg::SCALE_HALF: scaled = 20'(count_in) >> 1;
			default:              scaled = 20'(count_in);
		endcase
		if (full_ref == 8'h00)
			ratio = 20'h0_0000;
		else
			ratio = 20'((scaled << 4) / {full_ref, 8'h00});
		sixteenths = (ratio > 20'h0_000f) ? 4'hf : ratio[3:0];
	end
endmodule : bgrb_gauge_calc

//--- rtl/bgrb_pkg.sv
// Constants shared by the battery gauge register bank
package bgrb_pkg;
	localparam logic [6:0] ADDR_TEMP_GAUGE = 7'h02;
	localparam logic [6:0] ADDR_COUNT_HIGH = 7'h03;
	localparam logic [6:0] ADDR_PACK_ID    = 7'h04;
	localparam logic [6:0] ADDR_LEARNED    = 7'h05;
	localparam logic [6:0] ADDR_SEC_FLAGS  = 7'h06;
	localparam logic [6:0] ADDR_PULLDOWN   = 7'h07;
	localparam logic [6:0] ADDR_PULLUP     = 7'h08;
	localparam logic [6:0] ADDR_INACCURACY = 7'h09;
	localparam logic [6:0] ADDR_FILTER     = 7'h0a;
	localparam logic [6:0] ADDR_COUNT_LOW  = 7'h17;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h39;
	localparam logic [7:0] SOFT_RESET_ARM  = 8'h00;
	localparam logic [7:0] SOFT_RESET_FIRE = 8'h80;
	localparam int         CMD_WRITE_BIT   = 7;
	localparam logic [7:0] FILTER_RESET    = 8'h00;
	localparam logic [7:0] CPI_SATURATE    = 8'hff;
	localparam logic [7:0] CPI_FLAG_LEVEL  = 8'h40;
	localparam logic [3:0] TEMP_CODE_ZERO  = 4'h4;
	localparam logic [3:0] TEMP_CODE_M10   = 4'h3;
	localparam logic [3:0] TEMP_CODE_M20   = 4'h2;
	localparam logic [12:0] SELF_DISCH_MAX = 13'h1000;
	localparam int         CLK_HZ          = 40000000;
	localparam int         OVERLOAD_FLAG_HOLD_MS    = 500;
	localparam int         OVERLOAD_FLAG_HOLD_CYC   = CLK_HZ / 1000 * OVERLOAD_FLAG_HOLD_MS;
	typedef enum logic [1:0] {SCALE_FULL, SCALE_3Q, SCALE_HALF} bgrb_scale_e;
endpackage : bgrb_pkg

//--- rtl/bgrb_scale_sel.sv
// Temperature regime selection with hysteresis
`timescale 1ns/100ps
module bgrb_scale_sel (
	input  wire logic [3:0]            temp_code, // Temperature code
	input  wire bgrb_pkg::bgrb_scale_e cur,       // Present regime
	output bgrb_pkg::bgrb_scale_e      nxt        // Next regime
);
	always_comb begin
		if (temp_code < bgrb_pkg::TEMP_CODE_M20)
			nxt = bgrb_pkg::SCALE_HALF;
		else if (temp_code >= bgrb_pkg::TEMP_CODE_ZERO + 4'h1)
			nxt = bgrb_pkg::SCALE_FULL;
		else if (temp_code < bgrb_pkg::TEMP_CODE_ZERO)
			nxt = (cur == bgrb_pkg::SCALE_FULL && temp_code == bgrb_pkg::TEMP_CODE_M10)
				? bgrb_pkg::SCALE_FULL : bgrb_pkg::SCALE_3Q;
		else
			nxt = (cur == bgrb_pkg::SCALE_FULL) ? bgrb_pkg::SCALE_FULL : bgrb_pkg::SCALE_3Q;
	end
endmodule : bgrb_scale_sel

//--- rtl/bgrb_top.sv
// Battery gauge register bank top
`timescale 1ns/100ps
module bgrb_top #(
	parameter int OVERLOAD_FLAG_HOLD = bgrb_pkg::OVERLOAD_FLAG_HOLD_CYC
) (
	input  wire logic       CLK,              // Clock 40 MHz
	input  wire logic       RST_B,            // Synchronous reset, active low
	input  wire logic       CMD_VALID,        // Command byte with data strobe
	input  wire logic [7:0] COMMAND_BYTE,     // Bit 7 write, 6:0 address
	input  wire logic [7:0] WR_DATA,          // Write data byte
	output logic      [7:0] RD_DATA,          // Read data byte
	output logic            RD_VALID,         // Read data strobe
	input  wire logic [7:0] PROGRAMMED_FULL_CAPACITY, // Programmed full capacity
	input  wire logic       SIXTH_STRAP_INPUT,        // Strap, high loads count
	input  wire logic [5:0] PULLDOWN_SEEN,    // Pull-down found per output
	input  wire logic [5:0] PULLUP_SEEN,      // Pull-up found per output
	input  wire logic [3:0] TEMPERATURE_CODE, // Sensed temperature code
	input  wire logic       CHARGE_TICK,      // One charge count
	input  wire logic       DISCHARGE_TICK,   // One discharge count
	input  wire logic       SELF_DISCH_TICK,  // One self-discharge count
	input  wire logic       SLOW_CHARGE,      // Charge rate below 2 counts/sec
	input  wire logic       SENSE_BELOW_150,  // Sense voltage below -150 mV
	input  wire logic       SENSE_BELOW_250,  // Sense voltage below -250 mV
	input  wire logic       EMPTY_SAMPLE,     // Terminal below first empty level
	output logic [7:0]      TEMPERATURE_GAUGE_STATUS, // Status byte
	output logic [7:0]      SECONDARY_FLAGS,  // Secondary flags byte
	output logic [7:0]      MAGNITUDE_FILTER_THRESHOLD, // Valid thresholds
	output logic            RECALIBRATION_DUE_FLAG, // Recalibration due
	output logic            VALID_DISCHARGE_FLAG,   // Valid discharge
	output logic            PACK_REPLACED_FLAG,     // Pack replaced
	output logic            FIRST_EMPTY_WARNING,    // First empty latched
	output logic            EMPTY_SAMPLING_ON       // End-of-discharge sampling enabled
);
	typedef struct packed {
		logic [15:0] count;
		logic [7:0]  pack_id;
		logic [7:0]  learned;
		logic [7:0]  filter;
		logic [7:0]  inaccuracy_count;
		logic        cpi_armed;
		logic        recal;
		logic        valid_discharge_flag;
		logic        replaced;
		logic        empty;
		logic        fast;
		logic        charging;
		logic [12:0] self_cnt;
		logic [31:0] overload_flag_cnt;
		logic        sampling;
		bgrb_pkg::bgrb_scale_e scale;
		logic [7:0]  reset_reg;
		logic        soft_rst;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic [7:0]  status;
		logic [7:0]  flags2;
	} bgrb_state_s;

	bgrb_state_s st_ff;
	bgrb_state_s nxt_st;
	bgrb_pkg::bgrb_scale_e nxt_scale;
	logic [3:0]  gauge;

	bgrb_scale_sel u_scale (
		.temp_code (TEMPERATURE_CODE),
		.cur       (st_ff.scale),
		.nxt       (nxt_scale)
	);

	bgrb_gauge_calc u_gauge (
		.count_in   (st_ff.count),
		.full_ref   (st_ff.learned),
		.scale      (st_ff.scale),
		.sixteenths (gauge)
	);

	// Threshold of 0.94 times learned, in count units
	function automatic logic below_94(input logic [15:0] cnt, input logic [7:0] lrn);
		logic [23:0] lhs;
		logic [23:0] rhs;
		lhs = 24'(cnt) * 24'd100;
		rhs = 24'({lrn, 8'h00}) * 24'd94;
		return lhs < rhs;
	endfunction : below_94

	logic is_wr;
	logic [6:0] addr;
	logic charge_evt;
	logic [7:0] rd_mux;
	assign is_wr = COMMAND_BYTE[bgrb_pkg::CMD_WRITE_BIT];
	assign addr  = COMMAND_BYTE[6:0];

	always_comb begin
		case (addr)
			bgrb_pkg::ADDR_TEMP_GAUGE: rd_mux = st_ff.status;
			bgrb_pkg::ADDR_COUNT_HIGH: rd_mux = st_ff.count[15:8];
			bgrb_pkg::ADDR_PACK_ID:    rd_mux = st_ff.pack_id;
			bgrb_pkg::ADDR_LEARNED:    rd_mux = st_ff.learned;
			bgrb_pkg::ADDR_SEC_FLAGS:  rd_mux = st_ff.flags2;
			bgrb_pkg::ADDR_PULLDOWN:   rd_mux = {2'b00, PULLDOWN_SEEN};
			bgrb_pkg::ADDR_PULLUP:     rd_mux = {2'b00, PULLUP_SEEN};
			bgrb_pkg::ADDR_INACCURACY: rd_mux = st_ff.inaccuracy_count;
			bgrb_pkg::ADDR_FILTER:     rd_mux = st_ff.filter;
			bgrb_pkg::ADDR_COUNT_LOW:  rd_mux = st_ff.count[7:0];
			default:                   rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rd_valid = 1'b0;
		nxt_st.soft_rst = 1'b0;
		charge_evt = CHARGE_TICK && !st_ff.charging;
		if (CMD_VALID && !is_wr) begin
			nxt_st.rd_data  = rd_mux;
			nxt_st.rd_valid = 1'b1;
		end
		// Gauge counting
		if (CHARGE_TICK) begin
			nxt_st.count = (st_ff.count == 16'hffff) ? st_ff.count : st_ff.count + 16'h0001;
			nxt_st.charging = 1'b1;
			nxt_st.empty = 1'b0;
			nxt_st.valid_discharge_flag = 1'b0;
			if (charge_evt)
				nxt_st.fast = 1'b1;
		end else if (DISCHARGE_TICK || SELF_DISCH_TICK) begin
			nxt_st.count = (st_ff.count == 16'h0000) ? st_ff.count : st_ff.count - 16'h0001;
			nxt_st.charging = 1'b0;
			if (st_ff.count[15:8] == st_ff.learned && st_ff.count[7:0] == 8'h00 && DISCHARGE_TICK)
				nxt_st.valid_discharge_flag = 1'b1;
		end
		// A charge start in the same cycle as a slow report keeps the flag set
		if (SLOW_CHARGE && !charge_evt)
			nxt_st.fast = 1'b0;
		if (SELF_DISCH_TICK && st_ff.self_cnt != bgrb_pkg::SELF_DISCH_MAX)
			nxt_st.self_cnt = st_ff.self_cnt + 13'h0001;
		if (st_ff.self_cnt >= bgrb_pkg::SELF_DISCH_MAX)
			nxt_st.valid_discharge_flag = 1'b0;
		// Inaccuracy counter
		if (charge_evt) begin
			if (below_94(st_ff.count, st_ff.learned) || st_ff.cpi_armed) begin
				if (st_ff.inaccuracy_count != bgrb_pkg::CPI_SATURATE)
					nxt_st.inaccuracy_count = st_ff.inaccuracy_count + 8'h01;
				if (st_ff.inaccuracy_count + 8'h01 == bgrb_pkg::CPI_FLAG_LEVEL)
					nxt_st.recal = 1'b1;
				nxt_st.cpi_armed = 1'b0;
			end
		end
		if (below_94(st_ff.count, st_ff.learned))
			nxt_st.cpi_armed = 1'b1;
		// Overload hold-off
		if (SENSE_BELOW_250) begin
			nxt_st.overload_flag_cnt = 32'(OVERLOAD_FLAG_HOLD);
			nxt_st.sampling = 1'b0;
		end else if (st_ff.overload_flag_cnt != 32'h0000_0000) begin
			nxt_st.overload_flag_cnt = st_ff.overload_flag_cnt - 32'h0000_0001;
			nxt_st.sampling = (st_ff.overload_flag_cnt == 32'h0000_0001);
		end
		// First empty warning
		if (EMPTY_SAMPLE && st_ff.sampling && !st_ff.empty) begin
			nxt_st.empty = 1'b1;
			nxt_st.count = 16'h0000;
			if (st_ff.valid_discharge_flag && TEMPERATURE_CODE >= bgrb_pkg::TEMP_CODE_ZERO
				&& st_ff.self_cnt < bgrb_pkg::SELF_DISCH_MAX) begin
				nxt_st.learned = st_ff.learned - st_ff.count[15:8];
				nxt_st.inaccuracy_count   = 8'h00;
				nxt_st.recal = 1'b0;
			end
			nxt_st.valid_discharge_flag = 1'b0;
			nxt_st.self_cnt = 13'h0000;
		end
		// Host writes; read-only addresses fall through
		if (CMD_VALID && is_wr) begin
			case (addr)
				bgrb_pkg::ADDR_COUNT_HIGH: nxt_st.count[15:8] = WR_DATA;
				bgrb_pkg::ADDR_PACK_ID:    nxt_st.pack_id = WR_DATA;
				bgrb_pkg::ADDR_LEARNED:    nxt_st.learned = WR_DATA;
				bgrb_pkg::ADDR_FILTER:     nxt_st.filter  = WR_DATA;
				bgrb_pkg::ADDR_SOFT_RESET: begin
					nxt_st.reset_reg = WR_DATA;
					nxt_st.soft_rst  = (st_ff.reset_reg == bgrb_pkg::SOFT_RESET_ARM)
						&& (WR_DATA == bgrb_pkg::SOFT_RESET_FIRE);
				end
				default: nxt_st.rd_valid = nxt_st.rd_valid;
			endcase
		end
		nxt_st.scale  = nxt_scale;
		nxt_st.status = {TEMPERATURE_CODE, gauge};
		nxt_st.flags2 = {st_ff.fast, 2'b00, SENSE_BELOW_150, 3'b000, SENSE_BELOW_250};
		// Reset, hardware or register driven
		if (!RST_B || st_ff.soft_rst) begin
			nxt_st.learned   = PROGRAMMED_FULL_CAPACITY;
			nxt_st.count     = SIXTH_STRAP_INPUT ? {PROGRAMMED_FULL_CAPACITY, 8'h00}
				: 16'h0000;
			nxt_st.inaccuracy_count       = 8'h00;
			nxt_st.valid_discharge_flag       = 1'b0;
			nxt_st.recal     = 1'b1;
			nxt_st.replaced  = 1'b1;
			nxt_st.cpi_armed = 1'b1;
			nxt_st.empty     = 1'b0;
			nxt_st.fast      = 1'b0;
			nxt_st.charging  = 1'b0;
			nxt_st.self_cnt  = 13'h0000;
			nxt_st.overload_flag_cnt  = 32'h0000_0000;
			nxt_st.sampling  = 1'b1;
			nxt_st.reset_reg = 8'h00;
			nxt_st.soft_rst  = 1'b0;
			nxt_st.rd_valid  = 1'b0;
			nxt_st.scale     = bgrb_pkg::SCALE_FULL;
		end
		if (!RST_B) begin
			nxt_st.filter  = bgrb_pkg::FILTER_RESET;
			nxt_st.rd_data = 8'h00;
			nxt_st.status  = 8'h00;
			nxt_st.flags2  = 8'h00;
		end
		if (st_ff.replaced && (charge_evt && st_ff.empty
			|| CHARGE_TICK && st_ff.count[15:8] == st_ff.learned))
			nxt_st.replaced = 1'b0;
	end

	always_ff @(posedge CLK) begin
		st_ff <= nxt_st;
	end

	always_comb begin
		RD_DATA                    = st_ff.rd_data;
		RD_VALID                   = st_ff.rd_valid;
		TEMPERATURE_GAUGE_STATUS   = st_ff.status;
		SECONDARY_FLAGS            = st_ff.flags2;
		MAGNITUDE_FILTER_THRESHOLD = st_ff.filter;
		RECALIBRATION_DUE_FLAG     = st_ff.recal;
		VALID_DISCHARGE_FLAG       = st_ff.valid_discharge_flag;
		PACK_REPLACED_FLAG         = st_ff.replaced;
		FIRST_EMPTY_WARNING        = st_ff.empty;
		EMPTY_SAMPLING_ON          = st_ff.sampling;
	end
endmodule : bgrb_top

//--- sim/bgrb_host_model.sv
// Host model issuing serial-port commands to the register bank
`timescale 1ns/100ps
module bgrb_host_model (
	input  wire logic       CLK,          // Clock
	output logic            CMD_VALID,    // Command strobe
	output logic      [7:0] COMMAND_BYTE, // Command byte
	output logic      [7:0] WR_DATA,      // Write data
	input  wire logic [7:0] RD_DATA,      // Read data
	input  wire logic       RD_VALID      // Read strobe
);
	initial begin
		CMD_VALID = 1'b0;
		COMMAND_BYTE = 8'h00;
		WR_DATA = 8'h00;
	end
	task automatic send(input logic [7:0] cmd, input logic [7:0] data);
		@(posedge CLK);
		CMD_VALID <= 1'b1;
		COMMAND_BYTE <= cmd;
		WR_DATA <= data;
		@(posedge CLK);
		CMD_VALID <= 1'b0;
		// Idle lines never keep the last value
		COMMAND_BYTE <= ~cmd;
		WR_DATA <= ~data;
	endtask : send
	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		if (addr == bgrb_pkg::ADDR_SOFT_RESET && data[6:0] != 7'h00)
			return;
		send({1'b1, addr}, data);
	endtask : wr
	task automatic rd(input logic [6:0] addr, output logic [7:0] data);
		send({1'b0, addr}, 8'h00);
		@(posedge CLK);
		data = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
	endtask : rd
endmodule : bgrb_host_model

//--- sim/bgrb_top_sva.sv
// Port checker for the battery gauge register bank
`timescale 1ns/100ps
module bgrb_top_sva #(
	parameter int OVERLOAD_FLAG_HOLD = 8
) (
	input wire logic       CLK,                        // Clock
	input wire logic       RST_B,                      // Reset, active low
	input wire logic       CMD_VALID,                  // Command strobe
	input wire logic [7:0] COMMAND_BYTE,               // Command byte
	input wire logic [7:0] WR_DATA,                    // Write data
	input wire logic       RD_VALID,                   // Read strobe
	input wire logic [3:0] TEMPERATURE_CODE,           // Temperature code
	input wire logic       SENSE_BELOW_150,            // Heavy discharge
	input wire logic       SENSE_BELOW_250,            // Overload
	input wire logic [7:0] TEMPERATURE_GAUGE_STATUS,   // Status byte
	input wire logic [7:0] SECONDARY_FLAGS,            // Flags byte
	input wire logic [7:0] MAGNITUDE_FILTER_THRESHOLD, // Filter
	input wire logic       RECALIBRATION_DUE_FLAG,     // Recalibration due
	input wire logic       PACK_REPLACED_FLAG,         // Pack replaced
	input wire logic       EMPTY_SAMPLING_ON           // Sampling enabled
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	int off_cnt_ff;
	// Cycles with overload gone but sampling still off
	always_ff @(posedge CLK) begin
		if (!RST_B || SENSE_BELOW_250 || EMPTY_SAMPLING_ON)
			off_cnt_ff <= 0;
		else
			off_cnt_ff <= off_cnt_ff + 1;
	end
	AST_RD_LAT: assert property (CMD_VALID && !COMMAND_BYTE[7] |=> RD_VALID)
		else $error("read not answered one cycle later");
	AST_RD_IDLE: assert property (!(CMD_VALID && !COMMAND_BYTE[7]) |=> !RD_VALID)
		else $error("read strobe without a read");
	AST_TEMP: assert property ((RST_B && $stable(TEMPERATURE_CODE))[*3]
		|-> TEMPERATURE_GAUGE_STATUS[7:4] == TEMPERATURE_CODE)
		else $error("status temperature field wrong");
	AST_RATE: assert property ((RST_B && $stable(SENSE_BELOW_150))[*3]
		|-> SECONDARY_FLAGS[6:4] == {2'b00, SENSE_BELOW_150})
		else $error("discharge rate code wrong");
	AST_OVERLOAD_FLAG: assert property ((RST_B && $stable(SENSE_BELOW_250))[*3]
		|-> SECONDARY_FLAGS[0] == SENSE_BELOW_250)
		else $error("overload flag wrong");
	AST_SAMPLE_OFF: assert property ((RST_B && SENSE_BELOW_250)[*3] |-> !EMPTY_SAMPLING_ON)
		else $error("sampling left on in overload");
	AST_SAMPLE_BACK: assert property (off_cnt_ff <= OVERLOAD_FLAG_HOLD + 3)
		else $error("sampling not resumed after overload");
	AST_RESET_FLAGS: assert property ($rose(RST_B) |-> RECALIBRATION_DUE_FLAG && PACK_REPLACED_FLAG)
		else $error("reset flags not set");
	AST_FILTER_WR: assert property (CMD_VALID && COMMAND_BYTE == {1'b1, bgrb_pkg::ADDR_FILTER}
		|=> MAGNITUDE_FILTER_THRESHOLD == $past(WR_DATA))
		else $error("filter write not taken");
	cover property (CMD_VALID && !COMMAND_BYTE[7]);
	cover property ($fell(SENSE_BELOW_250));
	cover property ($rose(EMPTY_SAMPLING_ON));
endmodule : bgrb_top_sva
bind bgrb_top bgrb_top_sva #(.OVERLOAD_FLAG_HOLD(OVERLOAD_FLAG_HOLD)) u_sva (.CLK(CLK), .RST_B(RST_B),
	.CMD_VALID(CMD_VALID), .COMMAND_BYTE(COMMAND_BYTE), .WR_DATA(WR_DATA),
	.RD_VALID(RD_VALID), .TEMPERATURE_CODE(TEMPERATURE_CODE),
	.SENSE_BELOW_150(SENSE_BELOW_150), .SENSE_BELOW_250(SENSE_BELOW_250),
	.TEMPERATURE_GAUGE_STATUS(TEMPERATURE_GAUGE_STATUS), .SECONDARY_FLAGS(SECONDARY_FLAGS),
	.MAGNITUDE_FILTER_THRESHOLD(MAGNITUDE_FILTER_THRESHOLD),
	.RECALIBRATION_DUE_FLAG(RECALIBRATION_DUE_FLAG), .PACK_REPLACED_FLAG(PACK_REPLACED_FLAG),
	.EMPTY_SAMPLING_ON(EMPTY_SAMPLING_ON));

//--- sim/tb.sv
// Self-checking bench for the battery gauge register bank
`timescale 1ns/100ps
module tb;
	logic       clk, rst_b, cmd_v, rdv, strap, chg, dis, sdis, slow, s150, s250, empty;
	logic       recal, valid_discharge_flag, pack_replaced_flag, edv, samp;
	logic [7:0] cmd, wdat, rdat, programmed_full_capacity, status, flags, filt;
	logic [5:0] pd, pu;
	logic [3:0] temp;
	logic [6:0] ro[5] = '{7'h02, 7'h07, 7'h09, 7'h17, 7'h7f};
	logic [7:0] tc[9] = '{8'h58, 8'h38, 8'h26, 8'h36, 8'h46, 8'h58, 8'h14, 8'h04, 8'hc8};
	int         failures = 0;
	int         n_compared = 0;
	bgrb_host_model host (.CLK(clk), .CMD_VALID(cmd_v), .COMMAND_BYTE(cmd), .WR_DATA(wdat),
		.RD_DATA(rdat), .RD_VALID(rdv));
	bgrb_top #(.OVERLOAD_FLAG_HOLD(8)) u_bgrb_top (.CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_v),
		.COMMAND_BYTE(cmd), .WR_DATA(wdat), .RD_DATA(rdat), .RD_VALID(rdv),
		.PROGRAMMED_FULL_CAPACITY(programmed_full_capacity), .SIXTH_STRAP_INPUT(strap), .PULLDOWN_SEEN(pd),
		.PULLUP_SEEN(pu), .TEMPERATURE_CODE(temp), .CHARGE_TICK(chg), .DISCHARGE_TICK(dis),
		.SELF_DISCH_TICK(sdis), .SLOW_CHARGE(slow), .SENSE_BELOW_150(s150),
		.SENSE_BELOW_250(s250), .EMPTY_SAMPLE(empty), .TEMPERATURE_GAUGE_STATUS(status),
		.SECONDARY_FLAGS(flags), .MAGNITUDE_FILTER_THRESHOLD(filt),
		.RECALIBRATION_DUE_FLAG(recal), .VALID_DISCHARGE_FLAG(valid_discharge_flag), .PACK_REPLACED_FLAG(pack_replaced_flag),
		.FIRST_EMPTY_WARNING(edv), .EMPTY_SAMPLING_ON(samp));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, exp);
	endtask : rc
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One-cycle count pulse: charge, discharge, self-discharge
	task automatic tk(input logic [2:0] v);
		@(posedge clk);
		{chg, dis, sdis} <= v;
		@(posedge clk);
		{chg, dis, sdis} <= 3'b000;
	endtask : tk
	task automatic conclude();
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 5000);
		failures++;
		conclude();
	end
	initial begin
		{rst_b, chg, dis, sdis, slow, s150, s250, empty} = '0;
		{programmed_full_capacity, strap, pd, pu, temp} = {8'h20, 1'b1, 6'h09, 6'h24, 4'h5};
		cyc(6);
		rst_b <= 1'b1;
		rc(7'h05, 8'h20);
		rc(7'h03, 8'h20);
		rc(7'h17, 8'h00);
		rc(7'h09, 8'h00);
		rc(7'h07, 8'h09);
		rc(7'h08, 8'h24);
		rc(7'h02, 8'h5f);
		chk({6'h00, recal, pack_replaced_flag}, 8'h03);
		$display("test reset done");
		host.wr(7'h03, 8'h10);
		foreach (ro[i]) host.wr(ro[i], 8'hff);
		rc(7'h09, 8'h00);
		rc(7'h17, 8'h00);
		rc(7'h07, 8'h09);
		rc(7'h7f, 8'h00);
		rc(7'h02, 8'h58);
		host.wr(7'h04, 8'ha5);
		rc(7'h04, 8'ha5);
		host.wr(7'h0a, 8'h3c);
		rc(7'h0a, 8'h3c);
		chk(filt, 8'h3c);
		host.wr(7'h05, 8'h40);
		rc(7'h05, 8'h40);
		rc(7'h02, 8'h54);
		host.wr(7'h05, 8'h20);
		$display("test access done");
		foreach (tc[i]) begin
			@(posedge clk);
			temp <= tc[i][7:4];
			cyc(3);
			rc(7'h02, tc[i]);
		end
		temp <= 4'h5;
		$display("test temperature done");
		tk(3'b100);
		cyc(2);
		chk(flags, 8'h80);
		rc(7'h17, 8'h01);
		rc(7'h09, 8'h01);
		tk(3'b010);
		tk(3'b010);
		rc(7'h03, 8'h0f);
		rc(7'h17, 8'hff);
		slow <= 1'b1;
		cyc(3);
		chk(flags, 8'h00);
		tk(3'b100);
		rc(7'h09, 8'h02);
		tk(3'b001);
		rc(7'h17, 8'hff);
		$display("test counting done");
		s150 <= 1'b1;
		cyc(3);
		chk(flags, 8'h10);
		s250 <= 1'b1;
		cyc(4);
		chk({flags[0], samp}, 8'h02);
		{s150, s250} <= 2'b00;
		cyc(4);
		chk({7'h00, samp}, 8'h00);
		cyc(10);
		chk(flags, 8'h00);
		chk({7'h00, samp}, 8'h01);
		empty <= 1'b1;
		cyc(4);
		chk({7'h00, edv}, 8'h01);
		empty <= 1'b0;
		rc(7'h03, 8'h00);
		rc(7'h17, 8'h00);
		$display("test overload and empty done");
		{temp, strap} <= 5'h00;
		host.wr(7'h39, 8'h00);
		host.wr(7'h39, 8'h80);
		cyc(2);
		rc(7'h05, 8'h20);
		rc(7'h09, 8'h00);
		rc(7'h04, 8'ha5);
		chk({6'h00, recal, pack_replaced_flag}, 8'h03);
		$display("test soft reset done");
		temp <= 4'h5;
		host.wr(7'h03, 8'h20);
		tk(3'b010);
		cyc(1);
		chk({7'h00, valid_discharge_flag}, 8'h01);
		host.wr(7'h03, 8'h08);
		empty <= 1'b1;
		cyc(3);
		empty <= 1'b0;
		rc(7'h05, 8'h18);
		chk({6'h00, recal, valid_discharge_flag}, 8'h00);
		$display("test learning done");
		conclude();
	end
endmodule : tb
